// ### sac_sysref_align.sv
`default_nettype none
module sac_sysref_align (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic sysref_pin,
    input wire logic [23:0] window_detect_pin,
    input wire logic edge_aligned_pin,
    output logic clock_invert_delay,
    output logic [7:0] coarse_delay_step,
    output logic [7:0] fine_delay_step,
    output logic [3:0] capture_phase_select
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [25:0] sync1_reg;
    logic [25:0] sync2_reg;
    logic sysref_prev_reg;
    logic sysref_rise;
    logic aligned_now;
    logic [23:0] window_now;

    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sysref_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {edge_aligned_pin, sysref_pin, window_detect_pin};
            sync2_reg <= sync1_reg;
            sysref_prev_reg <= sync2_reg[24];
        end
    end

    always_comb begin
        sysref_rise = sync2_reg[24] & ~sysref_prev_reg;
        aligned_now = sync2_reg[25];
        window_now = sync2_reg[23:0];
    end

    // ------------------------------------------------------------
    // Software registers and capture window map
    // ------------------------------------------------------------
    logic [3:0] phase_sel_reg, phase_sel_next;
    logic [7:0] sw_fine_reg, sw_fine_next;
    logic [7:0] sw_coarse_reg, sw_coarse_next;
    logic sw_inv_reg, sw_inv_next;
    logic [7:0] cal_config_reg, cal_config_next;
    logic cal_enable_reg, cal_enable_next;
    logic [23:0] map_reg, map_next;
    logic [1:0] edge_count_reg, edge_count_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic map_valid;
    logic [23:0] map_view;

    // Calibration state, declared here because the register file reads it.
    sac_pkg::sac_cal_state_t cal_state_reg, cal_state_next;
    logic cal_done_reg, cal_done_next;
    logic cal_fail_reg, cal_fail_next;
    logic try_inv_reg, try_inv_next;
    logic [7:0] try_coarse_reg, try_coarse_next;
    logic [1:0] settle_count_reg, settle_count_next;
    logic res_inv_reg, res_inv_next;
    logic [7:0] res_coarse_reg, res_coarse_next;
    logic [7:0] res_fine_reg, res_fine_next;
    logic cal_start;
    logic cal_found;

    always_comb begin
        map_valid = (edge_count_reg == sac_pkg::SAC_MAP_VALID_EDGES);
        // Until three edges are seen every position is reported as suspect.
        map_view = map_valid ? (map_reg | sac_pkg::SAC_MAP_EDGE_BITS)
                             : sac_pkg::SAC_MAP_UNKNOWN; // [RQ16] [RQ17]
        phase_sel_next = phase_sel_reg;
        sw_fine_next = sw_fine_reg;
        sw_coarse_next = sw_coarse_reg;
        sw_inv_next = sw_inv_reg;
        cal_config_next = cal_config_reg;
        cal_enable_next = cal_enable_reg;
        map_next = map_reg;
        edge_count_next = edge_count_reg;
        rdata_next = rdata_reg;
        rvalid_next = reg_rd;
        if (sysref_rise) begin
            map_next = window_now;
            if (!map_valid) begin
                edge_count_next = edge_count_reg + 2'h1; // [RQ16]
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                sac_pkg::SAC_ADDR_CAPTURE_PHASE: phase_sel_next = reg_wdata[3:0]; // [RQ18]
                sac_pkg::SAC_ADDR_CAL_CONFIG: cal_config_next = reg_wdata;
                sac_pkg::SAC_ADDR_CAL_ENABLE: cal_enable_next = reg_wdata[0];
                default: begin
                end
            endcase
            // Delay writes are held off while calibration owns the delay line.
            if (!cal_enable_reg) begin // [RQ9] [RQ10]
                case (reg_addr)
                    sac_pkg::SAC_ADDR_DELAY_FINE: sw_fine_next = reg_wdata;
                    sac_pkg::SAC_ADDR_DELAY_COARSE: sw_coarse_next = reg_wdata;
                    sac_pkg::SAC_ADDR_DELAY_INVERT: sw_inv_next = reg_wdata[0];
                    default: begin
                    end
                endcase
            end
        end
        // The found setting seeds the software delay so disabling causes no jump.
        if (cal_state_reg == sac_pkg::SAC_CAL_SETTLE && cal_found) begin // [RQ8]
            sw_inv_next = try_inv_reg;
            sw_coarse_next = try_coarse_reg;
            sw_fine_next = res_fine_reg;
        end
        if (reg_rd) begin
            case (reg_addr)
                sac_pkg::SAC_ADDR_CAPTURE_PHASE: rdata_next = {4'h0, phase_sel_reg};
                sac_pkg::SAC_ADDR_MAP_LOW: rdata_next = map_view[7:0]; // [RQ1]
                sac_pkg::SAC_ADDR_MAP_MID: rdata_next = map_view[15:8]; // [RQ1]
                sac_pkg::SAC_ADDR_MAP_HIGH: rdata_next = map_view[23:16]; // [RQ1]
                sac_pkg::SAC_ADDR_DELAY_FINE: rdata_next = sw_fine_reg;
                sac_pkg::SAC_ADDR_DELAY_COARSE: rdata_next = sw_coarse_reg;
                sac_pkg::SAC_ADDR_DELAY_INVERT: rdata_next = {7'h00, sw_inv_reg};
                sac_pkg::SAC_ADDR_CAL_CONFIG: rdata_next = cal_config_reg;
                sac_pkg::SAC_ADDR_CAL_ENABLE: rdata_next = {7'h00, cal_enable_reg};
                sac_pkg::SAC_ADDR_CAL_STATUS: rdata_next = {5'h00, map_valid, cal_fail_reg, cal_done_reg}; // [RQ6]
                sac_pkg::SAC_ADDR_RESULT_FINE: rdata_next = res_fine_reg; // [RQ7]
                sac_pkg::SAC_ADDR_RESULT_COARSE: rdata_next = res_coarse_reg; // [RQ7]
                sac_pkg::SAC_ADDR_RESULT_INVERT: rdata_next = {7'h00, res_inv_reg}; // [RQ7]
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            phase_sel_reg <= 4'h0;
            sw_fine_reg <= sac_pkg::SAC_RESET_BYTE;
            sw_coarse_reg <= sac_pkg::SAC_RESET_BYTE;
            sw_inv_reg <= 1'b0;
            cal_config_reg <= sac_pkg::SAC_RESET_BYTE;
            cal_enable_reg <= 1'b0;
            map_reg <= '0;
            edge_count_reg <= 2'h0;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            phase_sel_reg <= phase_sel_next;
            sw_fine_reg <= sw_fine_next;
            sw_coarse_reg <= sw_coarse_next;
            sw_inv_reg <= sw_inv_next;
            cal_config_reg <= cal_config_next;
            cal_enable_reg <= cal_enable_next;
            map_reg <= map_next;
            edge_count_reg <= edge_count_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    // ------------------------------------------------------------
    // Alignment search
    // ------------------------------------------------------------
    logic cal_enable_prev_reg;
    logic inv_out_reg, inv_out_next;
    logic [7:0] coarse_out_reg, coarse_out_next;
    logic [7:0] fine_out_reg, fine_out_next;

    always_comb begin
        cal_start = cal_enable_reg & ~cal_enable_prev_reg;
        cal_found = (settle_count_reg == cal_config_reg[1:0]) & sysref_rise & aligned_now;
        cal_state_next = cal_state_reg;
        cal_done_next = cal_done_reg;
        cal_fail_next = cal_fail_reg;
        try_inv_next = try_inv_reg;
        try_coarse_next = try_coarse_reg;
        settle_count_next = settle_count_reg;
        res_inv_next = res_inv_reg;
        res_coarse_next = res_coarse_reg;
        res_fine_next = res_fine_reg;
        case (cal_state_reg)
            sac_pkg::SAC_CAL_IDLE: begin
                if (cal_start) begin
                    cal_state_next = sac_pkg::SAC_CAL_SETTLE;
                end
            end
            sac_pkg::SAC_CAL_SETTLE: begin
                if (!cal_enable_reg) begin
                    cal_state_next = sac_pkg::SAC_CAL_IDLE;
                end else if (sysref_rise) begin
                    // Wait config[1:0]+1 reference edges per step, then judge alignment.
                    if (settle_count_reg != cal_config_reg[1:0]) begin
                        settle_count_next = settle_count_reg + 2'h1;
                    end else if (aligned_now) begin // [RQ5]
                        res_inv_next = try_inv_reg;
                        res_coarse_next = try_coarse_reg;
                        cal_done_next = 1'b1; // [RQ6]
                        cal_state_next = sac_pkg::SAC_CAL_DONE;
                    end else begin
                        settle_count_next = 2'h0;
                        // Both polarities at each coarse step, so the first hit is the smallest.
                        if (!try_inv_reg) begin // [RQ13]
                            try_inv_next = 1'b1;
                        end else if (try_coarse_reg == sac_pkg::SAC_COARSE_LAST) begin
                            cal_fail_next = 1'b1;
                            cal_done_next = 1'b1;
                            cal_state_next = sac_pkg::SAC_CAL_DONE;
                        end else begin
                            try_inv_next = 1'b0; // [RQ13]
                            try_coarse_next = try_coarse_reg + 8'h01;
                        end
                    end
                end
            end
            sac_pkg::SAC_CAL_DONE: begin
                if (!cal_enable_reg) begin
                    cal_state_next = sac_pkg::SAC_CAL_IDLE;
                end
            end
            default: cal_state_next = sac_pkg::SAC_CAL_IDLE;
        endcase
        if (cal_start) begin
            cal_done_next = 1'b0; // [RQ19]
            cal_fail_next = 1'b0;
            try_inv_next = 1'b0;
            try_coarse_next = sac_pkg::SAC_RESET_BYTE;
            settle_count_next = 2'h0;
            res_fine_next = sw_fine_reg;
        end
        // The line follows the search while it runs, then the held result.
        if (cal_state_reg == sac_pkg::SAC_CAL_SETTLE) begin // [RQ5]
            inv_out_next = try_inv_reg;
            coarse_out_next = try_coarse_reg;
            fine_out_next = res_fine_reg;
        end else if (cal_state_reg == sac_pkg::SAC_CAL_DONE) begin // [RQ8]
            inv_out_next = res_inv_reg;
            coarse_out_next = res_coarse_reg;
            fine_out_next = res_fine_reg;
        end else begin // [RQ9] [RQ10]
            inv_out_next = sw_inv_reg;
            coarse_out_next = sw_coarse_reg;
            fine_out_next = sw_fine_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cal_state_reg <= sac_pkg::SAC_CAL_IDLE;
            cal_enable_prev_reg <= 1'b0;
            cal_done_reg <= 1'b0;
            cal_fail_reg <= 1'b0;
            try_inv_reg <= 1'b0;
            try_coarse_reg <= sac_pkg::SAC_RESET_BYTE;
            settle_count_reg <= 2'h0;
            res_inv_reg <= 1'b0;
            res_coarse_reg <= sac_pkg::SAC_RESET_BYTE;
            res_fine_reg <= sac_pkg::SAC_RESET_BYTE;
            inv_out_reg <= 1'b0;
            coarse_out_reg <= sac_pkg::SAC_RESET_BYTE;
            fine_out_reg <= sac_pkg::SAC_RESET_BYTE;
        end else begin
            cal_state_reg <= cal_state_next;
            cal_enable_prev_reg <= cal_enable_reg;
            cal_done_reg <= cal_done_next;
            cal_fail_reg <= cal_fail_next;
            try_inv_reg <= try_inv_next;
            try_coarse_reg <= try_coarse_next;
            settle_count_reg <= settle_count_next;
            res_inv_reg <= res_inv_next;
            res_coarse_reg <= res_coarse_next;
            res_fine_reg <= res_fine_next;
            inv_out_reg <= inv_out_next;
            coarse_out_reg <= coarse_out_next;
            fine_out_reg <= fine_out_next;
        end
    end

    always_comb begin
        reg_rdata = rdata_reg;
        reg_rdata_valid = rvalid_reg;
        clock_invert_delay = inv_out_reg;
        coarse_delay_step = coarse_out_reg;
        fine_delay_step = fine_out_reg;
        capture_phase_select = phase_sel_reg; // [RQ18]
    end

endmodule
`default_nettype wire

// ### sac_pkg.sv
// What this block, the software and the outside side do
// (RQ1) Capture window map is 24 bits in three bytes, lowest address smallest delay.
// (RQ2) Outside side supplies device clock and normal operation before calibration starts.
// (RQ3) Outside clock source keeps reference running periodically during calibration.
// (RQ4) Software writes calibration config first, then raises calibration enable.
// (RQ5) With enable high, sweep delay until clock falling edge meets reference rising edge.
// (RQ6) A completion flag lets software poll for the end of the search.
// (RQ7) On completion, the found delay setting is readable in a result field.
// (RQ8) The calibrated delay stays applied until power-down without software action.
// (RQ9) After calibration is disabled, software writes to the delay setting are accepted.
// (RQ10) A stored delay written at startup (invert, coarse, fine) replaces calibration.
// (RQ11) Software keeps converter calibration off while alignment calibration runs.
// (RQ12) Software holds capture phase select at zero while alignment calibration is used.
// (RQ13) Search tries coarse steps with both clock polarities, picks smallest coarse delay.
// (RQ14) Software continues startup only after calibration reports completion.
// (RQ15) Downstream receiver picks a suitable elastic buffer release point.
// (RQ16) Capture window map becomes valid only after three reference rising edges.
// (RQ17) Bits 0 and 23 of the capture window map always read as one.
// (RQ18) Capture phase select addresses only the first 16 capture positions.
// (RQ19) Completion flag clears when calibration starts, stays low until the search settles.
`default_nettype none
package sac_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] SAC_ADDR_CAPTURE_PHASE = 12'h029;
    localparam logic [11:0] SAC_ADDR_MAP_LOW = 12'h02c;
    localparam logic [11:0] SAC_ADDR_MAP_MID = 12'h02d;
    localparam logic [11:0] SAC_ADDR_MAP_HIGH = 12'h02e;
    localparam logic [11:0] SAC_ADDR_DELAY_FINE = 12'h030;
    localparam logic [11:0] SAC_ADDR_DELAY_COARSE = 12'h031;
    localparam logic [11:0] SAC_ADDR_DELAY_INVERT = 12'h032;
    localparam logic [11:0] SAC_ADDR_CAL_CONFIG = 12'h033;
    localparam logic [11:0] SAC_ADDR_CAL_ENABLE = 12'h034;
    localparam logic [11:0] SAC_ADDR_CAL_STATUS = 12'h035;
    localparam logic [11:0] SAC_ADDR_RESULT_FINE = 12'h036;
    localparam logic [11:0] SAC_ADDR_RESULT_COARSE = 12'h037;
    localparam logic [11:0] SAC_ADDR_RESULT_INVERT = 12'h038;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int SAC_STATUS_DONE_BIT = 0;
    localparam int SAC_STATUS_FAIL_BIT = 1;
    localparam int SAC_STATUS_MAP_VALID_BIT = 2;
    localparam int SAC_MAP_WIDTH = 24;
    localparam logic [1:0] SAC_MAP_VALID_EDGES = 2'h3;
    localparam logic [7:0] SAC_RESET_BYTE = 8'h00;
    localparam logic [7:0] SAC_COARSE_LAST = 8'hff;
    localparam logic [23:0] SAC_MAP_EDGE_BITS = 24'h800001;
    localparam logic [23:0] SAC_MAP_UNKNOWN = 24'hffffff;

    // ------------------------------------------------------------
    // Calibration states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SAC_CAL_IDLE = 3'b001,
        SAC_CAL_SETTLE = 3'b010,
        SAC_CAL_DONE = 3'b100
    } sac_cal_state_t;

endpackage
`default_nettype wire

// ### sac_props.sv
`default_nettype none
module sac_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic clock_invert_delay,
    input wire logic [7:0] coarse_delay_step,
    input wire logic [7:0] fine_delay_step,
    input wire logic [3:0] capture_phase_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Shadow of what software last wrote.
    // ------------------------------------------------------------
    logic en_reg, en_next, mapped;
    logic [7:0] coarse_reg, coarse_next;
    logic [3:0] sel_reg, sel_next;
    always_comb begin
        en_next = en_reg;
        coarse_next = coarse_reg;
        sel_next = sel_reg;
        if (reg_wr && reg_addr == sac_pkg::SAC_ADDR_CAL_ENABLE) en_next = reg_wdata[0];
        if (reg_wr && reg_addr == sac_pkg::SAC_ADDR_DELAY_COARSE) coarse_next = reg_wdata;
        if (reg_wr && reg_addr == sac_pkg::SAC_ADDR_CAPTURE_PHASE) sel_next = reg_wdata[3:0];
        mapped = reg_addr == sac_pkg::SAC_ADDR_CAPTURE_PHASE
            || (reg_addr >= sac_pkg::SAC_ADDR_MAP_LOW && reg_addr <= sac_pkg::SAC_ADDR_MAP_HIGH)
            || (reg_addr >= sac_pkg::SAC_ADDR_DELAY_FINE && reg_addr <= sac_pkg::SAC_ADDR_RESULT_INVERT);
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            en_reg <= 1'b0;
            coarse_reg <= 8'h00;
            sel_reg <= 4'h0;
        end else begin
            en_reg <= en_next;
            coarse_reg <= coarse_next;
            sel_reg <= sel_next;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence cal_start;
        reg_wr && reg_addr == sac_pkg::SAC_ADDR_CAL_ENABLE && reg_wdata[0] && !en_reg;
    endsequence
    sequence status_poll;
        reg_rd && reg_addr == sac_pkg::SAC_ADDR_CAL_STATUS;
    endsequence
    a_read_gets_answer: assert property (reg_rd |=> reg_rdata_valid)
        else $error("read got no answer");
    a_answer_needs_read: assert property (reg_rdata_valid |-> $past(reg_rd))
        else $error("answer without read");
    a_unmapped_reads_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_map_low_edge: assert property (reg_rd && reg_addr == sac_pkg::SAC_ADDR_MAP_LOW |=> reg_rdata[0])
        else $error("map bit 0 not set");
    a_map_high_edge: assert property (reg_rd && reg_addr == sac_pkg::SAC_ADDR_MAP_HIGH |=> reg_rdata[7])
        else $error("map bit 23 not set");
    a_done_clears_start: assert property (cal_start ##2 status_poll |=> !reg_rdata[0])
        else $error("done flag not cleared at start");
    a_delay_write_applied: assert property (!en_reg && reg_wr && reg_addr == sac_pkg::SAC_ADDR_DELAY_COARSE
        |=> ##[0:1] coarse_delay_step == coarse_reg) else $error("coarse write not applied");
    a_select_applied: assert property (reg_wr && reg_addr == sac_pkg::SAC_ADDR_CAPTURE_PHASE
        |=> ##[0:1] capture_phase_select == sel_reg) else $error("capture select not applied");
    a_delay_holds_idle: assert property (!en_reg && !$past(en_reg) && !$past(en_reg, 2) && !$past(en_reg, 3)
        && !$past(reg_wr) && !$past(reg_wr, 2)
        |-> $stable(coarse_delay_step) && $stable(fine_delay_step) && $stable(clock_invert_delay))
        else $error("delay changed while idle");
    a_rdata_holds: assert property (!$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule
bind sac_sysref_align sac_checker chk (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .clock_invert_delay(clock_invert_delay), .coarse_delay_step(coarse_delay_step),
    .fine_delay_step(fine_delay_step), .capture_phase_select(capture_phase_select));
`default_nettype wire

// ### sac_clock_source.sv
`default_nettype none
module sac_clock_source #(
    parameter int PERIOD = 16,
    parameter logic [23:0] WINDOW = 24'h3c0f18
) (
    input wire logic clock,
    input wire logic run,
    input wire logic [7:0] target_coarse,
    input wire logic target_invert,
    input wire logic [7:0] coarse_delay_step,
    input wire logic clock_invert_delay,
    output logic sysref_pin,
    output logic [23:0] window_detect_pin,
    output logic edge_aligned_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A fixed reference phase gives the same search result on every run, as a receiver release point needs.
    int count = 0;
    always @(posedge clock) count <= run ? (count + 1) % PERIOD : 0;
    // The reference is periodic while enabled and held low otherwise.
    assign sysref_pin = run && count < PERIOD / 2;
    assign window_detect_pin = WINDOW;
    assign edge_aligned_pin = run && coarse_delay_step == target_coarse && clock_invert_delay == target_invert;
endmodule
`default_nettype wire

// ### test_sysref_alignment_calibration.sv
`default_nettype none
module test_sysref_alignment_calibration;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, rst, reg_wr, reg_rd, reg_rdata_valid, sysref_pin, edge_aligned_pin, clock_invert_delay;
    logic sysref_run, target_invert;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, coarse_delay_step, fine_delay_step, target_coarse;
    logic [23:0] window_detect_pin;
    logic [3:0] capture_phase_select;
    int errors, tests_run;
    sac_sysref_align dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .sysref_pin(sysref_pin),
        .window_detect_pin(window_detect_pin), .edge_aligned_pin(edge_aligned_pin),
        .clock_invert_delay(clock_invert_delay), .coarse_delay_step(coarse_delay_step),
        .fine_delay_step(fine_delay_step), .capture_phase_select(capture_phase_select));
    sac_clock_source source (.clock(clock), .run(sysref_run), .target_coarse(target_coarse),
        .target_invert(target_invert), .coarse_delay_step(coarse_delay_step),
        .clock_invert_delay(clock_invert_delay), .sysref_pin(sysref_pin),
        .window_detect_pin(window_detect_pin), .edge_aligned_pin(edge_aligned_pin));
    always #5 clock = ~clock;
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] addr, input logic [7:0] data);
        @(negedge clock);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] addr, output logic [7:0] data);
        logic got;
        @(negedge clock);
        reg_addr = addr;
        reg_rd = 1'b1;
        got = 1'b0;
        data = 8'h00;
        for (int k = 0; k < 3 && !got; k++) begin
            @(negedge clock);
            reg_rd = 1'b0;
            if (reg_rdata_valid === 1'b1) begin
                got = 1'b1;
                data = reg_rdata;
            end
        end
        chk("read answer", 8'h01, {7'h00, got});
    endtask
    task automatic rdchk(input string name, input logic [11:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        rd(addr, v);
        chk(name, exp, v);
    endtask
    task automatic calibrate(input logic [7:0] fine, input logic [7:0] tc, input logic ti, input logic [7:0] cfg);
        logic [7:0] st;
        target_coarse = tc;
        target_invert = ti;
        wr(sac_pkg::SAC_ADDR_DELAY_FINE, fine);
        wr(sac_pkg::SAC_ADDR_CAL_CONFIG, cfg);
        wr(sac_pkg::SAC_ADDR_CAL_ENABLE, 8'h01);
        rdchk("status at start", sac_pkg::SAC_ADDR_CAL_STATUS, 8'h04);
        st = 8'h00;
        for (int k = 0; k < 300 && st[0] !== 1'b1; k++) rd(sac_pkg::SAC_ADDR_CAL_STATUS, st);
        chk("status at end", 8'h05, st);
        rdchk("result fine", sac_pkg::SAC_ADDR_RESULT_FINE, fine);
        rdchk("result coarse", sac_pkg::SAC_ADDR_RESULT_COARSE, tc);
        rdchk("result invert", sac_pkg::SAC_ADDR_RESULT_INVERT, {7'h00, ti});
        chk("applied coarse", tc, coarse_delay_step);
        chk("applied invert", {7'h00, ti}, {7'h00, clock_invert_delay});
        chk("applied fine", fine, fine_delay_step);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clock);
        errors++;
        $display("BAD watchdog expected finish seen timeout");
        summarize();
    end
    initial begin
        {clock, reg_wr, reg_rd, sysref_run, target_invert} = 5'h00;
        rst = 1'b1;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        target_coarse = 8'h00;
        errors = 0;
        tests_run = 0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        rdchk("status after reset", sac_pkg::SAC_ADDR_CAL_STATUS, 8'h00);
        rdchk("map high early", sac_pkg::SAC_ADDR_MAP_HIGH, 8'hff);
        sysref_run = 1'b1;
        repeat (24) @(negedge clock);
        rdchk("map low two edges", sac_pkg::SAC_ADDR_MAP_LOW, 8'hff);
        repeat (30) @(negedge clock);
        rdchk("map low", sac_pkg::SAC_ADDR_MAP_LOW, 8'h19);
        rdchk("map mid", sac_pkg::SAC_ADDR_MAP_MID, 8'h0f);
        rdchk("map high", sac_pkg::SAC_ADDR_MAP_HIGH, 8'hbc);
        rdchk("status map valid", sac_pkg::SAC_ADDR_CAL_STATUS, 8'h04);
        wr(sac_pkg::SAC_ADDR_MAP_LOW, 8'h00);
        rdchk("map low after write", sac_pkg::SAC_ADDR_MAP_LOW, 8'h19);
        rdchk("unmapped read", 12'h100, 8'h00);
        wr(sac_pkg::SAC_ADDR_CAPTURE_PHASE, 8'h0f);
        @(negedge clock);
        chk("capture select", 8'h0f, {4'h0, capture_phase_select});
        wr(sac_pkg::SAC_ADDR_CAPTURE_PHASE, 8'h00);
        @(negedge clock);
        chk("capture select zero", 8'h00, {4'h0, capture_phase_select});
        calibrate(8'h44, 8'h02, 1'b1, 8'h00);
        wr(sac_pkg::SAC_ADDR_DELAY_COARSE, 8'h77);
        @(negedge clock);
        chk("coarse while enabled", 8'h02, coarse_delay_step);
        wr(sac_pkg::SAC_ADDR_CAL_ENABLE, 8'h00);
        wr(sac_pkg::SAC_ADDR_DELAY_COARSE, 8'h10);
        wr(sac_pkg::SAC_ADDR_DELAY_FINE, 8'h20);
        wr(sac_pkg::SAC_ADDR_DELAY_INVERT, 8'h00);
        @(negedge clock);
        chk("stored coarse", 8'h10, coarse_delay_step);
        chk("stored fine", 8'h20, fine_delay_step);
        chk("stored invert", 8'h00, {7'h00, clock_invert_delay});
        repeat (50) @(negedge clock);
        chk("coarse held", 8'h10, coarse_delay_step);
        // Two reference edges per step give the line time to leave the stored delay before judging.
        calibrate(8'h20, 8'h00, 1'b0, 8'h01);
        wr(sac_pkg::SAC_ADDR_CAL_ENABLE, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
